// ===== rtl/ftu_trace_unit.sv
// Flow trace unit: trace capture, shared SRAM port arbitration and registers.
`timescale 1ns/100ps
`include "ftu_defines.svh"

// Behaviour
// - Capture every flow change while enabled and the FIFO has room
// - Trace writes win the SRAM port
// - Each packet is two 32-bit words
// - Packet only on non-sequential program counter
// - Enable bit gates packet capture; packets already queued still land
// - Auto stop when pointer hits watermark
// - Without watermark, wrap and overwrite oldest
// - Registers decoded at fixed base address
// - Exactly four registers are provided
// - Position holds pointer and wrap flag
// - Flow holds watermark, stop, halt bits
// - Base register reports SRAM location
// - SRAM stays general storage for processor
// - Software sets buffer start and size
// - Processor and trace share SRAM concurrently
module ftu_trace_unit
	import ftu_pkg::*;
#(
	parameter logic [31:0] SRAM_BASE = 32'h20000000,
	parameter int FIFO_DEPTH = 8
) (
	// Clock, reset and clock enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Execution trace interface from the processor
	input wire logic trc_valid,
	input wire logic trc_nonseq,
	input wire logic [31:0] trc_src_pc,
	input wire logic [31:0] trc_dst_pc,
	// Processor port towards the SRAM
	input wire logic cpu_req,
	input wire logic cpu_we,
	input wire logic [31:0] cpu_addr,
	input wire logic [31:0] cpu_wdata,
	input wire logic [3:0] cpu_wstrb,
	output logic cpu_gnt,
	// Shared SRAM port
	output ftu_sram_req_t sram_req,
	output logic sram_en,
	// Halt request towards the debug logic
	output logic halt_req,
	// AXI4-Lite register slave
	input wire logic [31:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [31:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready
);

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	logic [31:0] position_q;
	logic [31:0] master_q;
	logic [31:0] flow_q;
	logic trace_en;
	logic [31:0] buf_size;
	logic [31:0] buf_start;
	logic [31:0] ptr;
	logic [31:0] ptr_next;
	logic at_wm;
	logic step;
	logic wrapped;
	logic [31:0] ptr_step;
	// Only the page bits of an address select this block; the low bits pick the register.
	localparam logic [31:0] BASE_ADDR = `FTU_BASE_ADDR;

	// Software enable, cleared by hardware when the watermark stops tracing.
	assign trace_en = master_q[`FTU_MASTER_EN];
	// Buffer size is eight bytes shifted left by the mask; start is the pointer's aligned base.
	assign buf_size = `FTU_PKT_BYTES << master_q[`FTU_MASTER_MASK_LSB +: `FTU_MASTER_MASK_W];
	assign ptr = {position_q[31:`FTU_PTR_LSB], 3'h0};
	assign buf_start = ptr & ~(buf_size - 32'h1);
	assign ptr_next = ptr + `FTU_PKT_BYTES;
	// Leaving the last slot of the buffer returns to its start.
	assign wrapped = ((ptr_next & (buf_size - 32'h1)) == 32'h0);
	// The slot after this packet, folded back to the start at the buffer's end.
	assign ptr_step = wrapped ? buf_start : ptr_next;
	// The watermark is met by the address after the packet just stored, taken before any fold back to the start.
	assign at_wm = (ptr_next[31:`FTU_WM_LSB] == flow_q[31:`FTU_WM_LSB]);

	// ------------------------------------------------------------------------
	// Trace capture into the FIFO
	// ------------------------------------------------------------------------
	ftu_pkt_t cap_pkt;
	ftu_pkt_t out_pkt;
	logic cap_valid;
	logic cap_ready;
	logic out_valid;
	logic out_ready;
	logic overflow_q;

	// Trace events come from logic on this clock, so they need no synchroniser.
	// Only non-sequential changes make a packet, and only while enabled.
	assign cap_valid = trc_valid && trc_nonseq && trace_en;
	assign cap_pkt.src_word = trc_src_pc;
	assign cap_pkt.dst_word = trc_dst_pc;

	// The FIFO soaks up bursts of branches while each packet takes two port cycles.
	ftu_fifo #(
		.WIDTH($bits(ftu_pkt_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.in_valid(cap_valid),
		.in_ready(cap_ready),
		.in_data(cap_pkt),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(out_pkt)
	);

	// A packet offered while the FIFO is full is dropped; the processor
	// cannot be stalled, so the loss is recorded instead.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			overflow_q <= 1'b0;
		end else if (ce && cap_valid && !cap_ready) begin
			overflow_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------------------
	// Packet writer: two SRAM words per packet
	// ------------------------------------------------------------------------
	// Word sequencer for the packet at the head of the FIFO.
	ftu_wr_state_t st_q;
	logic [31:0] hold_dst_q;

	// The FIFO is drained only when starting a packet.
	assign out_ready = (st_q == FTU_ST_IDLE);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= FTU_ST_IDLE;
			hold_dst_q <= `FTU_RST_WORD;
		end else if (ce) begin
			case (st_q)
				FTU_ST_IDLE: begin
					if (out_valid) begin
						hold_dst_q <= out_pkt.dst_word;
						st_q <= FTU_ST_WORD0;
					end
				end
				FTU_ST_WORD0: begin
					st_q <= FTU_ST_WORD1;
				end
				FTU_ST_WORD1: begin
					st_q <= FTU_ST_IDLE;
				end
				default: begin
					st_q <= FTU_ST_IDLE;
				end
			endcase
		end
	end

	logic [31:0] src_q;
	// Source word of the packet in flight, taken with the FIFO pop.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_q <= `FTU_RST_WORD;
		end else if (ce && st_q == FTU_ST_IDLE && out_valid) begin
			src_q <= out_pkt.src_word;
		end
	end

	// One pointer step per packet, in the cycle that stores its second word.
	assign step = ce && (st_q == FTU_ST_WORD1);

	// ------------------------------------------------------------------------
	// SRAM arbitration
	// ------------------------------------------------------------------------
	// Trace words take the port; a processor request meeting one is not granted,
	// and the processor holds it, waiting two cycles at most per packet.
	always_comb begin
		sram_req = '0;
		sram_en = 1'b0;
		cpu_gnt = 1'b0;
		if (st_q == FTU_ST_WORD0 || st_q == FTU_ST_WORD1) begin
			sram_en = 1'b1;
			sram_req.we = 1'b1;
			sram_req.wstrb = 4'hf;
			sram_req.addr = (st_q == FTU_ST_WORD0) ? ptr : ptr + 32'h4;
			sram_req.wdata = (st_q == FTU_ST_WORD0) ? src_q : hold_dst_q;
		end else if (cpu_req) begin
			sram_en = 1'b1;
			cpu_gnt = 1'b1;
			sram_req.we = cpu_we;
			sram_req.addr = cpu_addr;
			sram_req.wdata = cpu_wdata;
			sram_req.wstrb = cpu_wstrb;
		end
	end

	// ------------------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------------------
	logic aw_hit_q;
	logic w_hit_q;
	logic [31:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic wr_go;
	logic [`FTU_OFS_W-1:0] wofs;
	logic wmap;
	logic rmap;

	// Readies drop while the clock enable is low, so no transfer is taken and then lost.
	// A response already shown still stands then; the master must not take it meanwhile.
	assign s_awready = ce && !aw_hit_q && !s_bvalid;
	assign s_wready = ce && !w_hit_q && !s_bvalid;
	assign wr_go = ce && aw_hit_q && w_hit_q && !s_bvalid;
	assign wofs = awaddr_q[`FTU_OFS_W-1:0];
	assign wmap = (awaddr_q[31:`FTU_OFS_W] == BASE_ADDR[31:`FTU_OFS_W]);
	assign rmap = (s_araddr[31:`FTU_OFS_W] == BASE_ADDR[31:`FTU_OFS_W]);

	// A write response is given only once address and data are both held.
	// Address and data are latched independently, in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hit_q <= 1'b0;
			w_hit_q <= 1'b0;
			awaddr_q <= `FTU_RST_WORD;
			wdata_q <= `FTU_RST_WORD;
			wstrb_q <= 4'h0;
			s_bvalid <= 1'b0;
			s_bresp <= `FTU_RESP_OKAY;
		end else if (ce) begin
			if (s_awvalid && s_awready) begin
				aw_hit_q <= 1'b1;
				awaddr_q <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_hit_q <= 1'b1;
				wdata_q <= s_wdata;
				wstrb_q <= s_wstrb;
			end
			if (wr_go) begin
				aw_hit_q <= 1'b0;
				w_hit_q <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= wmap ? `FTU_RESP_OKAY : `FTU_RESP_SLVERR;
			end else if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end

	// Byte-enable merge of software data into a register.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Master register: software enable, and hardware auto-stop.
	// Software may set or clear the enable at any time; a packet in the FIFO still lands.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			master_q <= `FTU_RST_WORD;
		end else if (ce) begin
			if (wr_go && wmap && wofs == `FTU_OFS_MASTER) begin
				master_q <= merge(master_q, wdata_q, wstrb_q);
			end
			// The stop follows the packet's write, so it wins over a software set.
			if (step && at_wm && flow_q[`FTU_FLOW_STOP]) begin
				master_q[`FTU_MASTER_EN] <= 1'b0;
			end
		end
	end

	// Flow register: watermark plus stop and halt controls.
	// The overflow position is read only, so a write never stores it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flow_q <= `FTU_RST_WORD;
		end else if (ce && wr_go && wmap && wofs == `FTU_OFS_FLOW) begin
			flow_q <= merge(flow_q, wdata_q, wstrb_q) & `FTU_FLOW_WMASK;
		end
	end

	// Position register: pointer and wrap flag, advanced per packet.
	// The two lowest bits are never stored and read as zero.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			position_q <= `FTU_RST_WORD;
		end else if (ce) begin
			if (step) begin
				// Hardware update wins over a coincident software write.
				position_q[31:`FTU_PTR_LSB] <= ptr_step[31:`FTU_PTR_LSB];
				if (wrapped) begin
					position_q[`FTU_POS_WRAP] <= 1'b1;
				end
			end else if (wr_go && wmap && wofs == `FTU_OFS_POSITION) begin
				position_q <= merge(position_q, wdata_q, wstrb_q) & `FTU_POS_WMASK;
			end
		end
	end

	// Halt request pulses when the watermark is reached with halting chosen.
	// The pulse lasts one cycle; whoever halts the processor must latch it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			halt_req <= 1'b0;
		end else if (ce) begin
			halt_req <= step && at_wm && flow_q[`FTU_FLOW_HALT];
		end
	end

	// Read channel: one outstanding read, answered the cycle after the take.
	// An unmapped page or an unknown offset answers with an error and zero data.
	assign s_arready = ce && !s_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_rvalid <= 1'b0;
			s_rdata <= `FTU_RST_WORD;
			s_rresp <= `FTU_RESP_OKAY;
		end else if (ce) begin
			if (s_arvalid && s_arready) begin
				s_rvalid <= 1'b1;
				s_rresp <= `FTU_RESP_OKAY;
				if (!rmap) begin
					s_rdata <= `FTU_RST_WORD;
					s_rresp <= `FTU_RESP_SLVERR;
				end else if (s_araddr[`FTU_OFS_W-1:0] == `FTU_OFS_POSITION) begin
					s_rdata <= position_q;
				end else if (s_araddr[`FTU_OFS_W-1:0] == `FTU_OFS_MASTER) begin
					s_rdata <= master_q;
				end else if (s_araddr[`FTU_OFS_W-1:0] == `FTU_OFS_FLOW) begin
					s_rdata <= {flow_q[31:`FTU_FLOW_OVF+1], overflow_q, flow_q[`FTU_FLOW_OVF-1:0]};
				end else if (s_araddr[`FTU_OFS_W-1:0] == `FTU_OFS_BASE) begin
					s_rdata <= SRAM_BASE;
				end else begin
					s_rdata <= `FTU_RST_WORD;
					s_rresp <= `FTU_RESP_SLVERR;
				end
			end else if (s_rvalid && s_rready) begin
				s_rvalid <= 1'b0;
			end
		end
	end

endmodule // ftu_trace_unit

// ===== rtl/ftu_defines.svh
// Register offsets, field positions and reset values of the flow trace unit.
`ifndef FTU_DEFINES_SVH
`define FTU_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define FTU_BASE_ADDR 32'h41006000
`define FTU_OFS_POSITION 12'h000
`define FTU_OFS_MASTER 12'h004
`define FTU_OFS_FLOW 12'h008
`define FTU_OFS_BASE 12'h00c
`define FTU_ADDR_LSB 2
`define FTU_OFS_W 12

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define FTU_POS_WRAP 2
`define FTU_PTR_LSB 3
`define FTU_MASTER_EN 31
`define FTU_MASTER_MASK_LSB 0
`define FTU_MASTER_MASK_W 5
`define FTU_FLOW_STOP 0
`define FTU_FLOW_HALT 1
`define FTU_WM_LSB 3
`define FTU_FLOW_OVF 2

// ----------------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------------
`define FTU_RST_WORD 32'h00000000
`define FTU_MIN_MASK 5'h00
`define FTU_PKT_BYTES 32'h00000008
`define FTU_FLOW_WMASK 32'hfffffffb
`define FTU_POS_WMASK 32'hfffffffc
`define FTU_RESP_OKAY 2'h0
`define FTU_RESP_SLVERR 2'h2

`endif

// ===== rtl/ftu_pkg.sv
// Types shared by the flow trace unit files.
package ftu_pkg;

	// ------------------------------------------------------------------------
	// Trace packet and SRAM request carriers
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [31:0] src_word;
		logic [31:0] dst_word;
	} ftu_pkt_t;

	typedef struct packed {
		logic        we;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
	} ftu_sram_req_t;

	typedef enum logic [1:0] {
		FTU_ST_IDLE = 2'h0,
		FTU_ST_WORD0 = 2'h1,
		FTU_ST_WORD1 = 2'h3
	} ftu_wr_state_t;

endpackage : ftu_pkg

// ===== rtl/ftu_fifo.sv
// Small synchronous FIFO of flip-flops with valid and ready on both sides.
`timescale 1ns/100ps

module ftu_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] rd_q;
	logic [AW-1:0] wr_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	// Full and empty come straight from the occupancy count.
	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign push = ce && in_valid && in_ready;
	assign pop = ce && out_valid && out_ready;

	// Storage is written without reset; only the pointers and the count carry control state.
	always_ff @(posedge aclk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// Pointers and count.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_q <= '0;
			wr_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + (AW+1)'(1);
			end else if (pop && !push) begin
				cnt_q <= cnt_q - (AW+1)'(1);
			end
		end
	end
endmodule // ftu_fifo

// ===== test/ftu_trace_unit_asserts.sv
// Port-level checks of the flow trace unit.
`timescale 1ns/100ps
module ftu_trace_unit_asserts
	import ftu_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Processor, SRAM and halt
	input wire logic cpu_req,
	input wire logic cpu_we,
	input wire logic [31:0] cpu_addr,
	input wire logic cpu_gnt,
	input wire ftu_sram_req_t sram_req,
	input wire logic sram_en,
	input wire logic halt_req,
	// Register bus
	input wire logic s_awvalid,
	input wire logic s_awready,
	input wire logic s_wvalid,
	input wire logic s_wready,
	input wire logic s_bvalid,
	input wire logic s_bready,
	input wire logic [1:0] s_bresp,
	input wire logic s_arvalid,
	input wire logic s_arready,
	input wire logic [31:0] s_araddr,
	input wire logic s_rvalid,
	input wire logic s_rready,
	input wire logic [31:0] s_rdata,
	input wire logic [1:0] s_rresp
);
	// --------
	// Checks
	// --------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_cpu_served: assert property (cpu_req |-> ##[0:100] cpu_gnt)
		else $error("processor request starved");
	a_gnt_routes: assert property (cpu_gnt |-> sram_en && sram_req.addr == cpu_addr
		&& sram_req.we == cpu_we) else $error("granted request not on SRAM port");
	a_trace_wins: assert property (sram_en && !cpu_gnt |-> sram_req.we
		&& sram_req.wstrb == 4'hf) else $error("trace slot not a full word write");
	a_word_pair: assert property (sram_en && !cpu_gnt && !sram_req.addr[2] |=> sram_en
		&& !cpu_gnt && sram_req.addr == $past(sram_req.addr) + 32'h4)
		else $error("second packet word missing");
	a_b_holds: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
		else $error("write response dropped");
	a_r_holds: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
		else $error("read data dropped");
	a_r_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
		else $error("read not answered");
	a_b_answer: assert property (s_awvalid && s_awready && s_wvalid && s_wready
		|-> ##[1:2] s_bvalid) else $error("write not answered");
	a_unmapped_err: assert property (s_arvalid && s_arready
		&& s_araddr[31:12] != 20'h41006 |=> s_rresp == 2'h2) else $error("no error");
	a_halt_pulse: assert property (halt_req |=> !halt_req)
		else $error("halt request longer than one cycle");
	a_ce_freeze: assert property (!ce |=> $stable(s_rvalid) && $stable(s_bvalid)
		&& $stable(halt_req)) else $error("state moved while clock enable low");

	// Main scenarios reached.
	c_trace_blocks: cover property (sram_en && !cpu_gnt && cpu_req);
	c_halt: cover property (halt_req);
	c_slverr: cover property (s_bvalid && s_bresp == 2'h2);
	c_ce_wait: cover property (!ce && s_arvalid);
endmodule // ftu_trace_unit_asserts

// ===== test/ftu_cpu_model.sv
// Processor model: SRAM requester and execution trace source.
`timescale 1ns/100ps
module ftu_cpu_model (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// SRAM request side
	output logic cpu_req,
	output logic cpu_we,
	output logic [31:0] cpu_addr,
	output logic [31:0] cpu_wdata,
	output logic [3:0] cpu_wstrb,
	input wire logic cpu_gnt,
	// Execution trace side
	output logic trc_valid,
	output logic trc_nonseq,
	output logic [31:0] trc_src_pc,
	output logic [31:0] trc_dst_pc
);
	int seed = 33925;
	logic gnt_s;

	// Everything starts quiet.
	initial begin
		{cpu_req, cpu_we, cpu_addr, cpu_wdata, cpu_wstrb} = '0;
		{trc_valid, trc_nonseq, trc_src_pc, trc_dst_pc} = '0;
	end

	// Grant is sampled mid-cycle, so the hold decision never races the edge.
	always @(negedge aclk) gnt_s <= cpu_gnt;

	// A request holds until granted; idle lines churn so stale values never look valid.
	always @(posedge aclk) begin
		if (!aresetn) cpu_req <= 1'b0;
		else if (!cpu_req || gnt_s) begin
			cpu_req <= ($random(seed) % 3) == 0;
			cpu_we <= 1'($random(seed));
			cpu_addr <= 32'h20000000 | (32'($random(seed)) & 32'hffc);
			cpu_wdata <= $random(seed);
			cpu_wstrb <= 4'($random(seed));
		end
	end

	// One trace slot per call, standing for one cycle.
	task automatic ev(input logic v, ns, output logic [31:0] s, d);
		s = $random(seed);
		d = $random(seed);
		trc_valid <= v;
		trc_nonseq <= ns;
		trc_src_pc <= s;
		trc_dst_pc <= d;
		@(posedge aclk);
	endtask
endmodule // ftu_cpu_model

// ===== test/ftu_trace_unit_test.sv
// Self-checking bench of the flow trace unit.
`timescale 1ns/100ps
`include "ftu_defines.svh"
module ftu_trace_unit_test
	import ftu_pkg::*;
;
	localparam logic [31:0] RAM = 32'h20000000;
	localparam logic [31:0] RB = `FTU_BASE_ADDR;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic ce = 1'b1;
	logic cpu_req, cpu_we, cpu_gnt, sram_en, halt_req, trc_valid, trc_nonseq;
	logic [31:0] cpu_addr, cpu_wdata, trc_src_pc, trc_dst_pc, s_rdata, ptr, start, size, s, d;
	logic [3:0] cpu_wstrb;
	logic [3:0] s_wstrb = 4'hf;
	ftu_sram_req_t sram_req;
	logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0, free = 0;
	logic [31:0] s_awaddr = 0, s_wdata = 0, s_araddr = 0;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0] s_bresp, s_rresp;
	logic [63:0] e;
	logic [63:0] exp_q[$];
	int fails = 0, check_count = 0, halts = 0;

	always #5 aclk = ~aclk;

	ftu_cpu_model u_cpu (.*);
	ftu_trace_unit #(.SRAM_BASE(RAM)) u_dut (.*);

	// --------
	// Helpers
	// --------
	task automatic check(input string nm, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One register access; ready is sampled mid-cycle so release follows the taking edge.
	task automatic acc(input logic wr, input logic [31:0] a, dx, input logic [1:0] er);
		logic ta, tw, td;
		logic [31:0] rv;
		logic [1:0] rs;
		if (wr) {s_awaddr, s_wdata, s_awvalid, s_wvalid, s_bready} <= {a, dx, 3'b111};
		else {s_araddr, s_arvalid, s_rready} <= {a, 2'b11};
		do begin
			@(negedge aclk);
			ta = wr ? s_awvalid && s_awready : s_arvalid && s_arready;
			tw = s_wvalid && s_wready;
			td = wr ? s_bvalid : s_rvalid;
			rv = s_rdata;
			rs = wr ? s_bresp : s_rresp;
			@(posedge aclk);
			if (ta && wr) s_awvalid <= 1'b0;
			if (ta && !wr) s_arvalid <= 1'b0;
			if (tw) s_wvalid <= 1'b0;
		end while (!td);
		{s_bready, s_rready} <= 2'b00;
		check("response", 32'(rs), 32'(er));
		if (!wr) check("read data", rv, dx);
		@(posedge aclk);
	endtask

	// Send one branch slot and note the packet the unit should store.
	task automatic tev(input logic ns, en);
		u_cpu.ev(1'b1, ns, s, d);
		if (ns && en) begin
			exp_q.push_back({ptr, s});
			exp_q.push_back({ptr + 32'h4, d});
			ptr = (ptr + 32'h8 == start + size) ? start : ptr + 32'h8;
		end
	endtask

	task automatic idle(input int n);
		repeat (n) u_cpu.ev(1'b0, 1'b0, s, d);
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Trace writes are matched in order against the notes left by the driver.
	always @(negedge aclk) begin
		if (halt_req) halts++;
		if (aresetn && sram_en && !cpu_gnt && !free) begin
			if (exp_q.size() == 0) begin
				fails++;
				$display("mismatch extra write expected none seen %h", sram_req.addr);
			end else begin
				e = exp_q.pop_front();
				check("sram addr", sram_req.addr, e[63:32]);
				check("sram data", sram_req.wdata, e[31:0]);
			end
		end
	end

	// A hang is cut short long after the sequence should have ended.
	initial begin
		#100000;
		fails++;
		$display("mismatch watchdog expected end seen hang");
		print_verdict;
	end

	// --------
	// Sequence
	// --------
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		acc(0, RB, 0, 0);
		acc(0, RB + 4, 0, 0);
		acc(0, RB + 8, 0, 0);
		acc(0, RB + 'hc, RAM, 0);
		acc(0, RB + 'h10, 0, 2'h2);
		acc(0, 32'h41007000, 0, 2'h2);
		acc(1, 32'h41007000, 0, 2'h2);
		$display("test registers done");
		repeat (4) tev(1'b1, 1'b0);
		idle(10);
		$display("test disabled done");
		// Two-packet buffer: the third packet lands over the first.
		start = RAM + 32'h100;
		size = 32'h10;
		ptr = start;
		acc(1, RB, start, 0);
		acc(1, RB + 4, 32'h80000001, 0);
		tev(1, 1); tev(0, 1); tev(1, 1); tev(1, 1);
		idle(20);
		check("pending", 32'(exp_q.size()), 0);
		acc(0, RB, start + 32'hc, 0);
		$display("test wrap done");
		// Watermark two packets on: stop and halt.
		start = RAM + 32'h200;
		size = 32'h100;
		ptr = start;
		acc(1, RB, start, 0);
		acc(1, RB + 8, start + 32'h13, 0);
		acc(1, RB + 4, 32'h80000005, 0);
		halts = 0;
		repeat (3) begin
			tev(1, ptr != start + 32'h10);
			idle(8);
		end
		acc(0, RB + 4, 32'h5, 0);
		acc(0, RB + 8, start + 32'h13, 0);
		check("halt pulses", 32'(halts), 1);
		// Software restarts, then stops tracing.
		acc(1, RB + 8, 0, 0);
		acc(1, RB + 4, 32'h80000005, 0);
		tev(1, 1);
		idle(8);
		acc(1, RB + 4, 32'h5, 0);
		tev(1, 0);
		idle(10);
		check("pending", 32'(exp_q.size()), 0);
		$display("test watermark done");
		// Clock enable low: a read offered meanwhile waits until it rises.
		ce <= 1'b0;
		fork
			acc(0, RB + 8, 0, 0);
			begin
				repeat (6) @(posedge aclk);
				ce <= 1'b1;
			end
		join
		$display("test clock enable done");
		// Flood the packet queue until it refuses; drops show as overflow.
		free = 1'b1;
		acc(1, RB + 4, 32'h80000005, 0);
		repeat (24) u_cpu.ev(1'b1, 1'b1, s, d);
		idle(80);
		acc(0, RB + 8, 32'h4, 0);
		$display("test overflow done");
		print_verdict;
	end
endmodule // ftu_trace_unit_test

bind ftu_trace_unit ftu_trace_unit_asserts u_chk (.*);
